// ==== bench/csc_cmd_engine_props.sv ====
`timescale 1ns/1ps
module csc_props (
	input wire logic        clk_in,
	input wire logic        reset_n_in,
	input wire logic [7:0]  addr_in,
	input wire logic        wr_in,
	input wire logic        rd_in,
	input wire logic [55:0] rd_data_out,
	input wire logic        conv_start_out,
	input wire logic [1:0]  conv_kind_out,
	input wire logic        conv_swap_out,
	input wire logic [15:0] conv_setup_out,
	input wire logic [15:0] conv_scale_out
);
	// ==========
	// stage history, a direct conversion must follow its own channel
	logic [1:0] last_kind_ff;
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			last_kind_ff <= 2'b00;
		end else if (conv_start_out) begin
			last_kind_ff <= conv_kind_out;
		end
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);
	// ==========
	// assertions
	a_swap_on_az: assert property (conv_start_out |-> conv_swap_out == !conv_kind_out[0])
		else $error("swap flag does not match stage kind");
	a_direct_after_az: assert property (conv_start_out && conv_kind_out[0] |-> last_kind_ff[1] == conv_kind_out[1])
		else $error("direct conversion without its auto-zero");
	a_start_gap: assert property (conv_start_out |=> !conv_start_out [*2])
		else $error("conversion requested while one is running");
	a_kind_hold: assert property (!conv_start_out |-> $stable(conv_kind_out) && $stable(conv_swap_out))
		else $error("stage kind changed without a request");
	a_setup_hold: assert property (!conv_start_out && !$past(wr_in) |-> $stable(conv_setup_out) && $stable(conv_scale_out))
		else $error("shadow setup changed without a request");
	a_status_fixed: assert property (rd_in && addr_in == 8'h00 |=> rd_data_out[55:54] == 2'b01 && !rd_data_out[48])
		else $error("status byte fixed bits wrong");
	a_mode_code: assert property (rd_in |=> !rd_data_out[52])
		else $error("reserved mode code reported");
	a_read_hold: assert property (!rd_in |=> $stable(rd_data_out))
		else $error("read data changed without a read");
	c_temp: cover property (conv_start_out && conv_kind_out == 2'b11);
	c_osr: cover property (conv_start_out && conv_setup_out[15:14] != 2'b00);
	c_cmd_mode: cover property (rd_in ##1 rd_data_out[52:51] == 2'b01);
endmodule
bind csc_cmd_engine csc_props i_props (
	.clk_in(clk_in),
	.reset_n_in(reset_n_in),
	.addr_in(addr_in),
	.wr_in(wr_in),
	.rd_in(rd_in),
	.rd_data_out(rd_data_out),
	.conv_start_out(conv_start_out),
	.conv_kind_out(conv_kind_out),
	.conv_swap_out(conv_swap_out),
	.conv_setup_out(conv_setup_out),
	.conv_scale_out(conv_scale_out)
);

// ==== bench/csc_cmd_engine_test.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; $display("[ERR] %0t got=%h exp=%h", $time, g, e); end end
module csc_cmd_engine_test;
	// ==========
	// wiring
	logic        clk_in        = 1'b0;
	logic        reset_n_in    = 1'b0;
	logic [7:0]  addr_in       = 8'h00;
	logic [15:0] wdata_in      = 16'h0000;
	logic        wr_in         = 1'b0;
	logic        rd_in         = 1'b0;
	logic        nvm_locked_in = 1'b0;
	logic [7:0]  lat           = 8'h03;
	logic [55:0] rd_data_out;
	logic        conv_start_out;
	logic [1:0]  conv_kind_out;
	logic        conv_swap_out;
	logic [15:0] conv_setup_out;
	logic [15:0] conv_scale_out;
	logic        conv_done_in;
	logic [23:0] conv_value_in;
	logic        conv_ovf_in;
	logic [7:0]  starts;
	logic [7:0]  s0;
	int          failures = 0;
	int          checked  = 0;
	// 40 mhz clock
	always #12.5 clk_in = ~clk_in;
	csc_cmd_engine i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .nvm_locked_in(nvm_locked_in),
		.conv_start_out(conv_start_out), .conv_kind_out(conv_kind_out), .conv_swap_out(conv_swap_out),
		.conv_setup_out(conv_setup_out), .conv_scale_out(conv_scale_out), .conv_done_in(conv_done_in),
		.conv_value_in(conv_value_in), .conv_ovf_in(conv_ovf_in));
	csc_conv_model i_conv (.clk_in(clk_in), .reset_n_in(reset_n_in), .start_in(conv_start_out),
		.kind_in(conv_kind_out), .lat_in(lat), .done_out(conv_done_in), .value_out(conv_value_in),
		.ovf_out(conv_ovf_in), .starts_out(starts));
	// ==========
	// bus tasks
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd();
		@(posedge clk_in);
		addr_in <= csc_pkg::RD_ADDR;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
	endtask
	task automatic summarize();
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// host polls busy
	// bounded poll of the busy flag before anything else is sent
	task automatic idle();
		int n;
		n = 0;
		rd();
		while (rd_data_out[53] !== 1'b0) begin
			n++;
			if (n > 400) begin
				failures++;
				summarize();
			end
			rd();
		end
	endtask
	task automatic cmd(input logic [7:0] a, input logic [15:0] d);
		wr(a, d);
		idle();
	endtask
	// polynomial 8005
	// expected checksum, msb first per word over words 0 to 1e
	function automatic logic [15:0] crc_of(input logic [15:0] w1, input logic [15:0] w28);
		logic [15:0] c;
		logic [15:0] w;
		c = 16'h0000;
		for (int i = 0; i < 31; i++) begin
			w = (i == 1) ? w1 : ((i == 28) ? w28 : 16'h0000);
			for (int b = 15; b >= 0; b--) begin
				c = {c[14:0], 1'b0} ^ ((c[15] ^ w[b]) ? 16'h8005 : 16'h0000);
			end
		end
		return c;
	endfunction
	// ==========
	// scenarios
	task automatic t_power();
		idle();
		`CHK(rd_data_out[55:48], 8'h40)
		cmd(csc_pkg::CMD_ENTER_COMMAND_MODE_CMD, 16'h0000);
		`CHK(rd_data_out[52:51], 2'b01)
		$display("test power done");
	endtask
	task automatic t_mem();
		cmd(8'h21, 16'h1234);
		cmd(8'h3c, 16'hbeef);
		`CHK(rd_data_out[47:0], 48'h0)
		@(posedge clk_in);
		nvm_locked_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		cmd(8'h22, 16'habcd);
		@(posedge clk_in);
		nvm_locked_in <= 1'b0;
		cmd(8'h01, 16'h0000);
		`CHK(rd_data_out[47:32], 16'h1234)
		cmd(8'h02, 16'h0000);
		`CHK(rd_data_out[47:32], 16'h0000)
		cmd(8'h1c, 16'h0000);
		`CHK(rd_data_out[47:32], 16'hbeef)
		rd();
		`CHK(rd_data_out[47:32], 16'hbeef)
		cmd(8'h3d, 16'h5555);
		`CHK(rd_data_out[47:32], 16'hbeef)
		cmd(8'h1d, 16'h0000);
		`CHK(rd_data_out[47:32], 16'h0000)
		$display("test mem done");
	endtask
	task automatic t_raw();
		s0 = starts;
		cmd(csc_pkg::CMD_RAW_S, 16'h0000);
		`CHK(rd_data_out[47:24], 24'h000800)
		`CHK(8'(starts - s0), 8'h02)
		lat <= 8'h28;
		s0 = starts;
		wr(csc_pkg::CMD_RAW_SX, 16'h4000);
		wr(8'h25, 16'h5555);
		idle();
		`CHK(8'(starts - s0), 8'h04)
		`CHK(rd_data_out[47:24], 24'h000800)
		`CHK(conv_setup_out, 16'h4000)
		lat <= 8'h03;
		cmd(8'h05, 16'h0000);
		`CHK(rd_data_out[47:32], 16'h0000)
		$display("test raw done");
	endtask
	task automatic t_meas();
		s0 = starts;
		cmd(csc_pkg::CMD_MEASURE, 16'h0000);
		`CHK(rd_data_out[47:0], 48'h800800800200)
		`CHK(8'(starts - s0), 8'h04)
		cmd(csc_pkg::CMD_RAW_T, 16'h0000);
		`CHK(rd_data_out[47:24], 24'h000200)
		cmd(csc_pkg::CMD_CRC, 16'h0000);
		cmd(8'h1f, 16'h0000);
		`CHK(rd_data_out[47:32], crc_of(16'h1234, 16'hbeef))
		$display("test measure done");
	endtask
	task automatic t_sleep();
		cmd(csc_pkg::CMD_SLEEP, 16'h0000);
		`CHK(rd_data_out[52:0], 53'h0)
		cmd(csc_pkg::CMD_ENTER_COMMAND_MODE_CMD, 16'h0000);
		`CHK(rd_data_out[52:51], 2'b00)
		// temperature and scaling words, four repeats per stage
		cmd(8'h24, 16'h8000);
		cmd(8'h25, 16'h0a5a);
		s0 = starts;
		cmd(csc_pkg::CMD_RAW_T, 16'h0000);
		`CHK(rd_data_out[47:24], 24'h000200)
		`CHK(8'(starts - s0), 8'h08)
		`CHK(conv_setup_out, 16'h8000)
		`CHK(conv_scale_out, 16'h0a5a)
		`CHK(conv_kind_out, 2'b11)
		`CHK(conv_swap_out, 1'b0)
		$display("test sleep done");
	endtask
	// reset for ten cycles, then the scenarios in order
	initial begin
		repeat (10) @(posedge clk_in);
		reset_n_in <= 1'b1;
		t_power();
		t_mem();
		t_raw();
		t_meas();
		t_sleep();
		summarize();
	end
endmodule

// ==== bench/csc_conv_model.sv ====
`timescale 1ns/1ps
module csc_conv_model (
	input  wire logic        clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        start_in,
	input  wire logic [1:0]  kind_in,
	input  wire logic [7:0]  lat_in,
	output logic             done_out,
	output logic      [23:0] value_out,
	output logic             ovf_out,
	output logic      [7:0]  starts_out
);
	// ==========
	// converter stand-in
	// even differences
	// readings per stage azs, sm, azt, tm chosen so the halved differences are exact
	localparam logic [23:0] VAL [4] = '{24'h000100, 24'h001100, 24'h000200, 24'h000600};
	logic [7:0] wait_ff;
	logic [1:0] kind_ff;
	logic       busy_ff;
	// one conversion in flight, answered lat_in plus one cycles late; starts counted for the bench
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			busy_ff <= 1'b0;
			wait_ff <= 8'h00;
			kind_ff <= 2'b00;
			done_out <= 1'b0;
			starts_out <= 8'h00;
		end else begin
			done_out <= busy_ff && wait_ff == 8'h00;
			if (start_in) begin
				busy_ff <= 1'b1;
				wait_ff <= lat_in;
				kind_ff <= kind_in;
				starts_out <= starts_out + 8'h01;
			end else if (busy_ff && wait_ff == 8'h00) begin
				busy_ff <= 1'b0;
			end else if (wait_ff != 8'h00) begin
				wait_ff <= wait_ff - 8'h01;
			end
		end
	end
	// value is inverted outside done so a mistimed sample shows up; overflow never raised
	assign value_out = done_out ? VAL[kind_ff] : ~VAL[kind_ff];
	assign ovf_out   = 1'b0;
endmodule

// ==== rtl/csc_cmd_engine.sv ====
`timescale 1ns/1ps
module csc_cmd_engine (
	input  wire logic        clk_in,
	input  wire logic        reset_n_in,
	input  wire logic [7:0]  addr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [55:0] rd_data_out,
	input  wire logic        nvm_locked_in,
	output logic             conv_start_out,
	output logic      [1:0]  conv_kind_out,
	output logic             conv_swap_out,
	output logic      [15:0] conv_setup_out,
	output logic      [15:0] conv_scale_out,
	input  wire logic        conv_done_in,
	input  wire logic [23:0] conv_value_in,
	input  wire logic        conv_ovf_in
);
	// ============================================================
	// state
	csc_pkg::csc_state_e state_ff;
	csc_pkg::csc_mode_e  mode_ff;
	csc_pkg::csc_stage_e stage_ff;
	csc_pkg::csc_stage_e last_stage_ff;
	logic [15:0] nvm_ff [csc_pkg::NVM_WORDS];
	logic        lock_meta_ff;
	logic        lock_ff;
	logic        first_ff;
	logic        measure_ff;
	logic [15:0] sens_setup_ff;
	logic [15:0] crc_ff;
	logic [4:0]  crc_idx_ff;
	logic        crc_store_ff;
	logic        mem_err_ff;
	logic        ovf_ff;
	logic [3:0]  rep_ff;
	logic [27:0] acc_ff;
	logic [23:0] az_ff;
	logic [23:0] sens_raw_ff;
	logic [47:0] result_ff;

	logic        busy;
	logic        accept;
	logic        is_rd;
	logic        is_wr;
	logic        is_meas;
	logic [4:0]  wr_idx;
	logic [15:0] crc_next;
	logic        crc_done;
	logic [1:0]  osr;
	logic [3:0]  reps;
	logic [27:0] acc_next;
	logic [23:0] avg;
	logic [24:0] diff;
	logic [23:0] raw;
	logic        store_last;

	// ============================================================
	// functions
	// one 16-bit word through the checksum shift register, msb first
	function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [15:0] d);
		logic [15:0] r;
		logic        fb;
		r = c;
		fb = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			fb = r[15] ^ d[i];
			r = {r[14:0], 1'b0};
			if (fb) begin
				r = r ^ csc_pkg::CRC_POLY;
			end
		end
		return r;
	endfunction

	// bias signed raw to unsigned range, msb-aligned corrected word
	function automatic logic [23:0] corr(input logic [23:0] r);
		return {~r[23], r[22:0]};
	endfunction

	// mode gate for every command code
	function automatic logic cmd_ok(input logic [7:0] c, input csc_pkg::csc_mode_e m, input logic first);
		logic normal;
		normal = (m != csc_pkg::CSC_CYCLIC);
		if (c <= csc_pkg::CMD_RD_LAST) begin
			return normal;
		end
		if (c >= csc_pkg::CMD_WR_BASE && c <= csc_pkg::CMD_WR_LAST) begin
			return normal;
		end
		unique case (c)
			csc_pkg::CMD_CRC, csc_pkg::CMD_RAW_S, csc_pkg::CMD_RAW_SX,
			csc_pkg::CMD_RAW_T, csc_pkg::CMD_MEASURE: begin
				return normal;
			end
			csc_pkg::CMD_SLEEP: begin
				return (m == csc_pkg::CSC_CMD) || (m == csc_pkg::CSC_CYCLIC);
			end
			csc_pkg::CMD_ENTER_COMMAND_MODE_CMD: begin
				return (m == csc_pkg::CSC_CMD) || first;
			end
			default: begin
				return 1'b0;
			end
		endcase
	endfunction

	// ============================================================
	// decode
	// busy gating
	assign busy = (state_ff != csc_pkg::CSC_IDLE);
	// mode gate; anything else is dropped here
	assign accept = wr_in && !busy && cmd_ok(addr_in, mode_ff, first_ff);
	assign is_rd = (addr_in <= csc_pkg::CMD_RD_LAST);
	assign is_wr = (addr_in >= csc_pkg::CMD_WR_BASE) && (addr_in <= csc_pkg::CMD_WR_LAST);
	assign is_meas = (addr_in == csc_pkg::CMD_RAW_S) || (addr_in == csc_pkg::CMD_RAW_SX) ||
		(addr_in == csc_pkg::CMD_RAW_T) || (addr_in == csc_pkg::CMD_MEASURE);
	// index is code minus write base
	assign wr_idx = 5'(addr_in - csc_pkg::CMD_WR_BASE);

	// checksum step over the current word
	assign crc_next = crc_word(crc_ff, nvm_ff[crc_idx_ff]);
	assign crc_done = (state_ff == csc_pkg::CSC_CRC) && (crc_idx_ff == csc_pkg::CRC_LAST);

	// repeat count doubles per oversampling step
	assign osr = conv_setup_out[csc_pkg::OSR_MSB:csc_pkg::OSR_LSB];
	assign reps = csc_pkg::REP_ONE << osr;
	assign acc_next = acc_ff + {{4{conv_value_in[23]}}, conv_value_in};
	assign avg = 24'($signed(acc_ff) >>> osr); // mean of the repeats, sign kept
	assign diff = {avg[23], avg} - {az_ff[23], az_ff};
	assign raw = diff[24:1];
	assign store_last = (state_ff == csc_pkg::CSC_STORE) && (stage_ff == last_stage_ff);

	// ============================================================
	// lock pin synchroniser
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			lock_meta_ff <= 1'b0;
			lock_ff <= 1'b0;
		end else begin
			lock_meta_ff <= nvm_locked_in;
			lock_ff <= lock_meta_ff;
		end
	end

	// ============================================================
	// memory words; flip-flops stand in for the nonvolatile array
	// 16-bit words
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			for (int i = 0; i < csc_pkg::NVM_WORDS; i++) begin
				nvm_ff[i] <= csc_pkg::NVM_RST;
			end
		end else if (accept && is_wr && !lock_ff && wr_idx <= csc_pkg::CUST_LAST) begin
			// locked writes dropped; factory words unreachable
			nvm_ff[wr_idx] <= wdata_in;
		end else if (crc_done && crc_store_ff) begin
			nvm_ff[csc_pkg::CRC_IDX] <= crc_next;
		end
	end

	// ============================================================
	// control sequencer; starts in checksum check straight after reset
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_ff <= csc_pkg::CSC_CRC;
		end else begin
			unique case (state_ff)
				csc_pkg::CSC_IDLE: begin
					if (accept && addr_in == csc_pkg::CMD_CRC) begin
						state_ff <= csc_pkg::CSC_CRC;
					end else if (accept && is_meas) begin
						state_ff <= csc_pkg::CSC_REQ;
					end
				end
				csc_pkg::CSC_REQ: begin
					state_ff <= csc_pkg::CSC_WAIT;
				end
				csc_pkg::CSC_WAIT: begin
					if (conv_done_in) begin
						state_ff <= (rep_ff == reps - csc_pkg::REP_ONE) ? csc_pkg::CSC_STORE : csc_pkg::CSC_REQ;
					end
				end
				csc_pkg::CSC_STORE: begin
					state_ff <= store_last ? csc_pkg::CSC_IDLE : csc_pkg::CSC_REQ;
				end
				csc_pkg::CSC_CRC: begin
					if (crc_done) begin
						state_ff <= csc_pkg::CSC_IDLE;
					end
				end
				default: begin
					state_ff <= csc_pkg::CSC_IDLE;
				end
			endcase
		end
	end

	// ============================================================
	// checksum engine and memory error flag
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			crc_ff <= csc_pkg::CRC_INIT;
			crc_idx_ff <= 5'h00;
			crc_store_ff <= 1'b0;
			mem_err_ff <= 1'b1;
		end else if (state_ff == csc_pkg::CSC_CRC) begin
			crc_ff <= crc_next;
			crc_idx_ff <= crc_idx_ff + 5'h01;
			// compare only on the power-on pass; flag follows result
			if (crc_done && !crc_store_ff) begin
				mem_err_ff <= (crc_next != nvm_ff[csc_pkg::CRC_IDX]);
			end
		end else if (accept && addr_in == csc_pkg::CMD_CRC) begin
			// command pass stores instead of comparing
			crc_ff <= csc_pkg::CRC_INIT;
			crc_idx_ff <= 5'h00;
			crc_store_ff <= 1'b1;
		end
	end

	// ============================================================
	// operating mode
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			mode_ff <= csc_pkg::CSC_SLEEP;
			first_ff <= 1'b1;
		end else begin
			if (crc_done && !crc_store_ff && nvm_ff[csc_pkg::SETUP_IDX][csc_pkg::CYCLIC_BIT]) begin
				mode_ff <= csc_pkg::CSC_CYCLIC;
			end
			if (accept) begin
				first_ff <= 1'b0;
			end
			if (accept && addr_in == csc_pkg::CMD_SLEEP) begin
				mode_ff <= csc_pkg::CSC_SLEEP;
			end
			if (accept && addr_in == csc_pkg::CMD_ENTER_COMMAND_MODE_CMD) begin
				mode_ff <= csc_pkg::CSC_CMD;
			end
		end
	end

	// ============================================================
	// measurement sequence setup
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			stage_ff <= csc_pkg::STG_AZS;
			last_stage_ff <= csc_pkg::STG_SM;
			measure_ff <= 1'b0;
			sens_setup_ff <= csc_pkg::NVM_RST;
		end else if (accept && is_meas) begin
			measure_ff <= (addr_in == csc_pkg::CMD_MEASURE);
			// host setup word replaces stored one
			if (addr_in == csc_pkg::CMD_RAW_SX) begin
				sens_setup_ff <= wdata_in;
			end else begin
				sens_setup_ff <= nvm_ff[csc_pkg::SENS_IDX];
			end
			stage_ff <= (addr_in == csc_pkg::CMD_RAW_T) ? csc_pkg::STG_AZT : csc_pkg::STG_AZS;
			last_stage_ff <= (addr_in == csc_pkg::CMD_RAW_S || addr_in == csc_pkg::CMD_RAW_SX) ?
				csc_pkg::STG_SM : csc_pkg::STG_TM;
		end else if (state_ff == csc_pkg::CSC_STORE && !store_last) begin
			stage_ff <= csc_pkg::csc_stage_e'(stage_ff + 2'b01);
		end
	end

	// ============================================================
	// converter request; shadow setup loaded per conversion
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			conv_start_out <= 1'b0;
			conv_kind_out <= csc_pkg::STG_AZS;
			conv_swap_out <= 1'b0;
			conv_setup_out <= csc_pkg::NVM_RST;
			conv_scale_out <= csc_pkg::NVM_RST;
		end else begin
			conv_start_out <= (state_ff == csc_pkg::CSC_REQ);
			if (state_ff == csc_pkg::CSC_REQ) begin
				conv_kind_out <= stage_ff;
				// auto-zero stages keep setup, swap inputs and offsets
				conv_swap_out <= !stage_ff[0];
				// temperature stages use temperature and scaling words
				conv_setup_out <= stage_ff[1] ? nvm_ff[csc_pkg::TEMP_IDX] : sens_setup_ff;
				conv_scale_out <= nvm_ff[csc_pkg::SCALE_IDX];
			end else if (accept && is_meas) begin
				// setup must be valid before the first request for the repeat count
				conv_setup_out <= (addr_in == csc_pkg::CMD_RAW_T) ? nvm_ff[csc_pkg::TEMP_IDX] :
					(addr_in == csc_pkg::CMD_RAW_SX) ? wdata_in : nvm_ff[csc_pkg::SENS_IDX];
			end
		end
	end

	// ============================================================
	// accumulation, auto-zero and raw values
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rep_ff <= 4'h0;
			acc_ff <= csc_pkg::ACC_ZERO;
			az_ff <= csc_pkg::RAW_ZERO;
			sens_raw_ff <= csc_pkg::RAW_ZERO;
		end else if (state_ff == csc_pkg::CSC_WAIT && conv_done_in) begin
			// one more conversion per oversampling repeat
			acc_ff <= acc_next;
			rep_ff <= rep_ff + 4'h1;
		end else if (state_ff == csc_pkg::CSC_STORE) begin
			acc_ff <= csc_pkg::ACC_ZERO;
			rep_ff <= 4'h0;
			if (!stage_ff[0]) begin
				az_ff <= avg;
			end else if (stage_ff == csc_pkg::STG_SM) begin
				sens_raw_ff <= raw;
			end
		end
	end

	// ============================================================
	// result word and overflow flag
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			result_ff <= csc_pkg::DATA_NONE;
			ovf_ff <= 1'b0;
		end else if (accept) begin
			// a new command clears old data; sleep leaves none
			ovf_ff <= 1'b0;
			result_ff <= is_rd ? {nvm_ff[addr_in[4:0]], csc_pkg::PAD16} : csc_pkg::DATA_NONE;
		end else begin
			// overflow only watched on capacitive conversions
			if (state_ff == csc_pkg::CSC_WAIT && conv_done_in && !stage_ff[1] && conv_ovf_in) begin
				ovf_ff <= 1'b1;
			end
			if (store_last) begin
				if (measure_ff) begin
					result_ff <= {corr(sens_raw_ff), corr(raw)};
				end else begin
					result_ff <= {raw, csc_pkg::WORD_NONE};
				end
			end
		end
	end

	// ============================================================
	// read port; same data on every repeat read
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rd_data_out <= {8'h00, csc_pkg::DATA_NONE};
		end else if (rd_in && addr_in == csc_pkg::RD_ADDR) begin
			rd_data_out <= {csc_pkg::ST_RSVD, csc_pkg::ST_POWER, busy,
				(mode_ff == csc_pkg::CSC_CMD) ? csc_pkg::MODE_CMDST : csc_pkg::MODE_NORMAL,
				mem_err_ff, ovf_ff, csc_pkg::ST_NOSAT, result_ff};
		end else if (rd_in) begin
			rd_data_out <= {8'h00, csc_pkg::DATA_NONE};
		end
	end
endmodule

// ==== rtl/csc_pkg.sv ====
// ============================================================
// Contract
// - results are 24-bit words: raw right-justified, corrected left-justified
// - auto-zeroed raw value is half of direct minus auto-zero measurement
// - auto-zero conversion keeps setup but swaps amplifier inputs and offsets
// - full measure runs sensor AZ, sensor, temp AZ, temp; returns two words
// - raw sensor command takes zero word, uses stored sensor setup, returns raw
// - raw sensor with setup uses the host word instead of the stored setup
// - raw temperature loads temp and scaling setup, auto-zeroes, returns raw
// - memory-read codes return the 16-bit word at that address
// - write codes store data at index code minus write base
// - writes while memory is locked are discarded without change
// - checksum command computes memory checksum and stores it in memory
// - sleep command enters sleep; its response is status byte only
// - enter-command-mode must come first after power-up; enables command mode
// - commands accepted only in allowed modes; cyclic accepts only sleep; code also accepts enter-command-mode there as the first command
// - checksum uses polynomial x^16 + x^15 + x^2 + 1 over whole memory; code covers words 0 to 1e, not the checksum word 1f
// - verification only after power-on; pass clears memory error flag
// - memory is 16-bit words, 28 customer words; code lets writes reach 29 words, 0 to 1c
// - ordinary writes reach only customer sector, never factory trim words
// - oversampling lengthens measurement time in proportion to factor
// - raw commands bypass all digital correction
// - read gives status byte then data of previous command; new command clears it
// - busy set while executing; new commands ignored while busy
// - status bits 4:3 give mode: 00 normal, 01 command
// - status bit 2 is 0 on checksum pass, 1 on fail
package csc_pkg;
	// ============================================================
	// command codes
	localparam logic [7:0] CMD_RD_LAST  = 8'h1f;
	localparam logic [7:0] CMD_WR_BASE  = 8'h20;
	localparam logic [7:0] CMD_WR_LAST  = 8'h3c;
	localparam logic [7:0] CMD_CRC      = 8'h90;
	localparam logic [7:0] CMD_RAW_S    = 8'ha2;
	localparam logic [7:0] CMD_RAW_SX   = 8'ha3;
	localparam logic [7:0] CMD_RAW_T    = 8'ha6;
	localparam logic [7:0] CMD_SLEEP    = 8'ha8;
	localparam logic [7:0] CMD_ENTER_COMMAND_MODE_CMD = 8'ha9;
	localparam logic [7:0] CMD_MEASURE  = 8'haa;
	// ============================================================
	// memory map
	localparam int         NVM_WORDS  = 32;
	localparam logic [4:0] CUST_LAST  = 5'h1c;
	localparam logic [4:0] CRC_LAST   = 5'h1e;
	localparam logic [4:0] CRC_IDX    = 5'h1f;
	localparam logic [4:0] SETUP_IDX  = 5'h02;
	localparam logic [4:0] SENS_IDX   = 5'h03;
	localparam logic [4:0] TEMP_IDX   = 5'h04;
	localparam logic [4:0] SCALE_IDX  = 5'h05;
	localparam int         CYCLIC_BIT = 15;
	localparam int         OSR_MSB    = 15;
	localparam int         OSR_LSB    = 14;
	localparam logic [15:0] CRC_POLY  = 16'h8005;
	localparam logic [15:0] CRC_INIT  = 16'h0000;
	localparam logic [15:0] NVM_RST   = 16'h0000;
	// ============================================================
	// read port and status
	localparam logic [7:0]  RD_ADDR   = 8'h00;
	localparam logic [47:0] DATA_NONE = 48'h0;
	localparam logic [23:0] WORD_NONE = 24'h0;
	localparam logic [31:0] PAD16     = 32'h0;
	localparam logic [3:0]  REP_ONE   = 4'h1;
	localparam logic [27:0] ACC_ZERO  = 28'h0;
	localparam logic [23:0] RAW_ZERO  = 24'h0;
	localparam logic        ST_RSVD   = 1'b0;
	localparam logic        ST_POWER  = 1'b1;
	localparam logic        ST_NOSAT  = 1'b0;
	// ============================================================
	// types
	typedef enum logic [1:0] {
		CSC_SLEEP  = 2'b00,
		CSC_CMD    = 2'b01,
		CSC_CYCLIC = 2'b10
	} csc_mode_e;
	typedef enum logic [2:0] {
		CSC_IDLE  = 3'b000,
		CSC_REQ   = 3'b001,
		CSC_WAIT  = 3'b011,
		CSC_STORE = 3'b010,
		CSC_CRC   = 3'b110
	} csc_state_e;
	typedef enum logic [1:0] {
		STG_AZS = 2'b00,
		STG_SM  = 2'b01,
		STG_AZT = 2'b10,
		STG_TM  = 2'b11
	} csc_stage_e;
	localparam logic [1:0] MODE_NORMAL = 2'b00;
	localparam logic [1:0] MODE_CMDST  = 2'b01;
endpackage
